/* cbo_gapped_clk.sv */
package cbo_pkg;
  localparam int CBO_IDX_W = 5;
  // overhead clock phase times and derived cycle counts at the 10 MHz clock
  localparam int CBO_CLK_NS = 100;
  localparam int CBO_HIGH_NS = 200;
  localparam int CBO_LOW_NS = 200;
  localparam int CBO_HIGH_CYC = (CBO_HIGH_NS + CBO_CLK_NS - 1) / CBO_CLK_NS;
  localparam int CBO_LOW_CYC = (CBO_LOW_NS + CBO_CLK_NS - 1) / CBO_CLK_NS;
  localparam int CBO_CNT_W = 4;
  // c-bit positions within the frame
  localparam logic [4:0] CBO_POS_C1 = 5'h01;
  localparam logic [4:0] CBO_POS_C2 = 5'h02;
  localparam logic [4:0] CBO_POS_C3 = 5'h03;
  localparam logic [4:0] CBO_POS_C6 = 5'h06;
  localparam logic [4:0] CBO_POS_C13 = 5'h0d;
  localparam logic [4:0] CBO_POS_C15 = 5'h0f;
  localparam logic [4:0] CBO_POS_C16 = 5'h10;
  localparam logic [4:0] CBO_POS_C21 = 5'h15;
  localparam logic CBO_DATA_RST = 1'b1;

  typedef enum logic [1:0] {
    CBO_GC_IDLE = 2'b01,
    CBO_GC_RUN = 2'b10
  } cbo_gc_state_e;

  function automatic logic cbo_rx_sel(input logic [4:0] idx);
    cbo_rx_sel = (idx >= CBO_POS_C2 && idx <= CBO_POS_C6) ||
                 (idx >= CBO_POS_C13 && idx <= CBO_POS_C21);
  endfunction : cbo_rx_sel

  function automatic logic cbo_tx_sel(input logic [4:0] idx, input logic c3_ext);
    cbo_tx_sel = cbo_rx_sel(idx) && ((idx != CBO_POS_C3) || c3_ext);
  endfunction : cbo_tx_sel
endpackage : cbo_pkg

`timescale 1ns/10ps

module cbo_gapped_clk
  import cbo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic clk_out
);
  cbo_gc_state_e state_reg;
  logic [CBO_CNT_W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // one high phase then one low phase per start; starts while busy are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= CBO_GC_IDLE;
      cnt_reg <= '0;
      clk_out <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        CBO_GC_IDLE:
        begin
          if (start)
          begin
            state_reg <= CBO_GC_RUN;
            clk_out <= 1'b1;
            cnt_reg <= CBO_CNT_W'(CBO_HIGH_CYC + CBO_LOW_CYC - 1);
          end
        end
        CBO_GC_RUN:
        begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == CBO_CNT_W'(CBO_LOW_CYC))
            clk_out <= 1'b0;
          if (cnt_reg == '0)
            state_reg <= CBO_GC_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_reg == CBO_GC_RUN);
endmodule : cbo_gapped_clk

/* cbo_ds3_cbit_port.sv */
`timescale 1ns/10ps

module cbo_ds3_cbit_port
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_slot_valid,
  input wire logic [cbo_pkg::CBO_IDX_W-1:0] rx_slot_index,
  input wire logic rx_slot_bit,
  input wire logic tx_slot_valid,
  input wire logic [cbo_pkg::CBO_IDX_W-1:0] tx_slot_index,
  input wire logic external_c3_select,
  input wire logic link_marker_enable,
  input wire logic tx_overhead_data,
  output logic rx_overhead_clock,
  output logic rx_overhead_data,
  output logic rx_overhead_frame_pulse,
  output logic rx_link_marker,
  output logic rx_link_marker_oe,
  output logic tx_overhead_clock,
  output logic tx_overhead_frame_pulse,
  output logic tx_link_marker,
  output logic tx_link_marker_oe,
  output logic tx_bit_valid,
  output logic [cbo_pkg::CBO_IDX_W-1:0] tx_bit_index,
  output logic tx_bit_value
);
  import cbo_pkg::*;

  logic rx_busy;
  logic tx_busy;
  logic rx_start;
  logic tx_start;
  logic [CBO_IDX_W-1:0] rx_cur_idx_reg;
  logic rx_frame_reg;
  logic rx_mark_reg;
  logic tx_frame_reg;
  logic tx_mark_reg;
  logic [2:0] tx_data_sync_reg;
  logic tx_data_filt_reg;
  logic [2:0] lme_sync_reg;
  logic lme_filt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_data_sync_reg <= 3'h7;
      tx_data_filt_reg <= CBO_DATA_RST;
    end
    else
    begin
      tx_data_sync_reg <= {tx_data_sync_reg[1:0], tx_overhead_data};
      if (tx_data_sync_reg[1] == tx_data_sync_reg[2])
        tx_data_filt_reg <= tx_data_sync_reg[2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lme_sync_reg <= 3'h0;
      lme_filt_reg <= 1'b0;
    end
    else
    begin
      lme_sync_reg <= {lme_sync_reg[1:0], link_marker_enable};
      if (lme_sync_reg[1] == lme_sync_reg[2])
        lme_filt_reg <= lme_sync_reg[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive side
  assign rx_start = rx_slot_valid && cbo_rx_sel(rx_slot_index) && !rx_busy;

  cbo_gapped_clk u_rx_clk (
    .clk(clk),
    .rst_n(rst_n),
    .start(rx_start),
    .busy(rx_busy),
    .clk_out(rx_overhead_clock)
  );

  // data and clock both move on the start cycle, so data changes with the rise
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_overhead_data <= CBO_DATA_RST;
      rx_cur_idx_reg <= '0;
    end
    else if (rx_start)
    begin
      rx_overhead_data <= rx_slot_bit;
      rx_cur_idx_reg <= rx_slot_index;
    end
  end

  // frame pulse runs from the C1 slot until the C2 slot starts
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_frame_reg <= 1'b0;
    else if (rx_slot_valid && rx_slot_index == CBO_POS_C1)
      rx_frame_reg <= 1'b1;
    else if (rx_slot_valid && rx_slot_index == CBO_POS_C2)
      rx_frame_reg <= 1'b0;
  end

  // marker rises with the C13 clock and falls at the C16 slot, covering C15's low phase
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_mark_reg <= 1'b0;
    else if (rx_slot_valid && rx_slot_index == CBO_POS_C13)
      rx_mark_reg <= 1'b1;
    else if (rx_slot_valid && rx_slot_index == CBO_POS_C16)
      rx_mark_reg <= 1'b0;
  end

  assign rx_overhead_frame_pulse = rx_frame_reg;
  // the marker value is held low while released so the bench never sees a stale level
  assign rx_link_marker = rx_mark_reg && lme_filt_reg;
  assign rx_link_marker_oe = lme_filt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // transmit side
  logic [CBO_IDX_W-1:0] tx_cur_idx_reg;

  assign tx_start = tx_slot_valid && cbo_tx_sel(tx_slot_index, external_c3_select)
                    && !tx_busy;

  cbo_gapped_clk u_tx_clk (
    .clk(clk),
    .rst_n(rst_n),
    .start(tx_start),
    .busy(tx_busy),
    .clk_out(tx_overhead_clock)
  );

  // the filtered pin value at the rise reflects data set after the previous rise;
  // this relies on the clock period exceeding the synchroniser delay
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_bit_valid <= 1'b0;
      tx_bit_index <= '0;
      tx_bit_value <= CBO_DATA_RST;
      tx_cur_idx_reg <= '0;
    end
    else
    begin
      tx_bit_valid <= tx_start;
      if (tx_start)
      begin
        tx_bit_index <= tx_slot_index;
        tx_bit_value <= tx_data_filt_reg;
        tx_cur_idx_reg <= tx_slot_index;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_frame_reg <= 1'b0;
    else if (tx_slot_valid && tx_slot_index == CBO_POS_C1)
      tx_frame_reg <= 1'b1;
    else if (tx_slot_valid && tx_slot_index == CBO_POS_C2)
      tx_frame_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tx_mark_reg <= 1'b0;
    else if (tx_slot_valid && tx_slot_index == CBO_POS_C13)
      tx_mark_reg <= 1'b1;
    else if (tx_slot_valid && tx_slot_index == CBO_POS_C16)
      tx_mark_reg <= 1'b0;
  end

  assign tx_overhead_frame_pulse = tx_frame_reg;
  assign tx_link_marker = tx_mark_reg && lme_filt_reg;
  assign tx_link_marker_oe = lme_filt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_rx_data_rise: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rx_overhead_clock) |-> rx_overhead_data == $past(rx_slot_bit))
    else $error("receive data not loaded with clock rise");

  a_rx_slot_select: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rx_overhead_clock) |->
      $past(rx_slot_valid) && cbo_rx_sel(rx_cur_idx_reg))
    else $error("receive clock pulsed for unselected position");

  a_rx_clk_shape: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rx_overhead_clock) |-> rx_overhead_clock ##1 rx_overhead_clock
      ##1 !rx_overhead_clock ##1 !rx_overhead_clock)
    else $error("receive clock phase length wrong");

  a_frame_before_c2: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rx_overhead_clock) && rx_cur_idx_reg == CBO_POS_C2 |->
      $past(rx_overhead_frame_pulse) && !rx_overhead_frame_pulse)
    else $error("receive frame pulse not ahead of C2");

  a_marker_span: assert property (@(posedge clk) disable iff (!rst_n)
    rx_overhead_clock && rx_link_marker |->
      rx_cur_idx_reg >= CBO_POS_C13 && rx_cur_idx_reg <= CBO_POS_C15)
    else $error("receive marker outside data link positions");

  a_marker_release: assert property (@(posedge clk) disable iff (!rst_n)
    !lme_filt_reg |-> !rx_link_marker_oe && !tx_link_marker_oe
      && !rx_link_marker && !tx_link_marker)
    else $error("marker driven while disabled");

  a_tx_c3_select: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tx_overhead_clock) && tx_cur_idx_reg == CBO_POS_C3 |->
      $past(external_c3_select))
    else $error("transmit clock pulsed for C3 while not selected");

  a_tx_capture: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tx_overhead_clock) |-> tx_bit_valid && tx_bit_value == $past(tx_data_filt_reg))
    else $error("transmit bit not captured at clock rise");
endmodule : cbo_ds3_cbit_port

/* cbo_cbit_partner.sv */
`timescale 1ns/10ps

// outside c-bit logic: steps through the clocked positions and feeds the transmit bit
module cbo_cbit_partner
(
  input wire logic tx_overhead_clock,
  input wire logic tx_overhead_frame_pulse,
  input wire logic external_c3_select,
  input wire logic [21:0] pattern,
  input wire logic [21:0] used,
  output logic tx_overhead_data
);
  logic [4:0] pos = 5'h02;

  function automatic logic [4:0] nxt(input logic [4:0] p, input logic c3);
    nxt = (p == 5'h02) ? (c3 ? 5'h03 : 5'h04) : (p == 5'h06) ? 5'h0d :
          (p == 5'h15) ? 5'h02 : p + 5'h01;
  endfunction : nxt

  // positions the far side leaves unused go out as ones
  function automatic logic bit_for(input logic [4:0] p);
    bit_for = used[p] ? pattern[p] : 1'b1;
  endfunction : bit_for

  initial tx_overhead_data = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // new bit just after each rise, so it has settled well before the next one
  always @(posedge tx_overhead_frame_pulse)
  begin
    pos = 5'h02;
    #5 tx_overhead_data = bit_for(pos);
  end

  always @(posedge tx_overhead_clock)
  begin
    pos = nxt(pos, external_c3_select);
    #5 tx_overhead_data = bit_for(pos);
  end
endmodule : cbo_cbit_partner

/* cbo_ds3_cbit_port_tb.sv */
`timescale 1ns/10ps

module cbo_ds3_cbit_port_tb;
  import cbo_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_slot_valid = 1'b0, rx_slot_bit = 1'b0, tx_slot_valid = 1'b0;
  logic [CBO_IDX_W-1:0] rx_slot_index = 5'h00, tx_slot_index = 5'h00;
  logic external_c3_select = 1'b0, link_marker_enable = 1'b0;
  logic tx_overhead_data;
  logic rx_overhead_clock, rx_overhead_data, rx_overhead_frame_pulse, rx_link_marker;
  logic rx_link_marker_oe, tx_overhead_clock, tx_overhead_frame_pulse, tx_link_marker;
  logic tx_link_marker_oe, tx_bit_valid, tx_bit_value;
  logic [CBO_IDX_W-1:0] tx_bit_index;
  logic [21:0] pattern = 22'h0, used = 22'h0;
  logic [7:0] seed = 8'h1a;
  logic [5:0] rx_q[$];
  logic [4:0] tx_q[$];
  logic [5:0] e;
  logic [4:0] ti;
  logic rxc_q = 1'b0, rxf_q = 1'b0, txc_q = 1'b0, txf_q = 1'b0, en_cur = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int t;

  always #50 clk = ~clk;

  cbo_ds3_cbit_port u_cbo_ds3_cbit_port (.clk, .rst_n, .rx_slot_valid, .rx_slot_index,
    .rx_slot_bit, .tx_slot_valid, .tx_slot_index, .external_c3_select, .link_marker_enable,
    .tx_overhead_data, .rx_overhead_clock, .rx_overhead_data, .rx_overhead_frame_pulse,
    .rx_link_marker, .rx_link_marker_oe, .tx_overhead_clock, .tx_overhead_frame_pulse,
    .tx_link_marker, .tx_link_marker_oe, .tx_bit_valid, .tx_bit_index, .tx_bit_value);

  cbo_cbit_partner u_cbo_cbit_partner (.tx_overhead_clock, .tx_overhead_frame_pulse,
    .external_c3_select, .pattern, .used, .tx_overhead_data);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  function automatic logic sel(input int i, input logic tx, input logic c3);
    sel = ((i >= 2 && i <= 6) || (i >= 13 && i <= 21)) && !(tx && i == 3 && !c3);
  endfunction : sel

  function automatic logic mk(input logic [4:0] i);
    mk = en_cur && i >= 5'h0d && i <= 5'h0f;
  endfunction : mk

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (!ok)
    begin
      $display("ERROR %0t %s", $time, msg);
      fail_count++;
    end
  endtask : check

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // slots 8 cycles apart: the pin filter needs about 4 before each rise
  task automatic run_frame(input logic c3, input logic en);
    int i;
    external_c3_select <= c3;
    link_marker_enable <= en;
    en_cur = en;
    for (i = 0; i < 22; i++)
    begin
      seed = lfsr_next(seed);
      pattern[i] = seed[0];
      used[i] = seed[1];
    end
    repeat (8) @(posedge clk);
    for (i = 1; i <= 21; i++)
    begin
      seed = lfsr_next(seed);
      rx_slot_valid <= 1'b1;
      rx_slot_index <= i[4:0];
      rx_slot_bit <= seed[0];
      tx_slot_valid <= 1'b1;
      tx_slot_index <= i[4:0];
      if (sel(i, 1'b0, c3)) rx_q.push_back({seed[0], i[4:0]});
      if (sel(i, 1'b1, c3)) tx_q.push_back(i[4:0]);
      @(posedge clk);
      rx_slot_valid <= 1'b0;
      tx_slot_valid <= 1'b0;
      repeat (7) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    check(rx_q.size() == 0 && tx_q.size() == 0, "positions missing");
    $display("frame done c3=%0b en=%0b", c3, en);
  endtask : run_frame

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
  begin
    if (rst_n && rx_overhead_clock && !rxc_q)
    begin
      e = (rx_q.size() > 0) ? rx_q.pop_front() : 6'h3f;
      check(e[4:0] != 5'h1f, "rx clock on unselected");
      check(rx_overhead_data === e[5], "rx data");
      check(rxf_q === (e[4:0] == 5'h02), "rx frame pulse");
      check(rx_link_marker === mk(e[4:0]), "rx marker");
      check(rx_link_marker_oe === en_cur, "rx marker oe");
    end
    if (rst_n)
      check(tx_bit_valid === (tx_overhead_clock && !txc_q), "tx valid vs clock");
    if (rst_n && tx_overhead_clock && !txc_q)
    begin
      ti = (tx_q.size() > 0) ? tx_q.pop_front() : 5'h1f;
      check(tx_bit_index === ti, "tx position");
      check(tx_bit_value === (used[ti] ? pattern[ti] : 1'b1), "tx sampled bit");
      check(txf_q === (ti == 5'h02), "tx frame pulse");
      check(tx_link_marker === mk(ti), "tx marker");
      check(tx_link_marker_oe === en_cur, "tx marker oe");
    end
    rxc_q = rx_overhead_clock;
    rxf_q = rx_overhead_frame_pulse;
    txc_q = tx_overhead_clock;
    txf_q = tx_overhead_frame_pulse;
  end

  // a hang ends the run well past the expected 1107 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run_frame(1'b0, 1'b1);
    run_frame(1'b1, 1'b0);
    for (t = 0; t < 4; t++)
    begin
      seed = lfsr_next(seed);
      run_frame(seed[2], seed[3]);
    end
    summarize();
  end
endmodule : cbo_ds3_cbit_port_tb
